// ### core/usr_regs.svh
`ifndef USR_REGS_SVH
`define USR_REGS_SVH
// ****************************************************************
// register offsets (word index on the register port)
// ****************************************************************
`define USR_OFF_MODE     3'h0
`define USR_OFF_STATUS   3'h1
`define USR_OFF_TXDATA   3'h2
`define USR_OFF_RXDATA   3'h3
`define USR_OFF_IRQ_STAT 3'h4
`define USR_OFF_IRQ_MASK 3'h5
`define USR_OFF_BAUD_DIV 3'h6
// ****************************************************************
// mode register fields
// ****************************************************************
`define USR_MODE_EN      15
`define USR_MODE_INV     4
`define USR_MODE_HS      3
`define USR_MODE_FMT_HI  2
`define USR_MODE_FMT_LO  1
`define USR_MODE_STOP2   0
// ****************************************************************
// status register fields
// ****************************************************************
`define USR_STA_TXEMPTY  8
`define USR_STA_RXSEL_HI 7
`define USR_STA_RXSEL_LO 6
`define USR_STA_ADDRESS_DETECT_ENABLE    5
`define USR_STA_IDLE     4
`define USR_STA_PARITY_ERROR_FLAG     3
`define USR_STA_FRAMING_ERROR_FLAG     2
`define USR_STA_OVR      1
`define USR_STA_AVAIL    0
// ****************************************************************
// interrupt status and mask bits
// ****************************************************************
`define USR_IRQ_RX       0
`define USR_IRQ_OVR      1
`define USR_IRQ_ERR      2
`define USR_IRQ_TXDONE   3
// ****************************************************************
// encodings, reset values and timing counts
// ****************************************************************
`define USR_FMT_NINE     2'h3
`define USR_FMT_ODD      2'h2
`define USR_FMT_EVEN     2'h1
`define USR_RXSEL_FOUR   2'h3
`define USR_RXSEL_THREE  2'h2
`define USR_RST_MODE     16'h0000
`define USR_RST_BAUD_DIV 16'h0003
`define USR_RST_MASK     4'h0
`define USR_OS_HS        5'h04
`define USR_OS_STD       5'h10
`define USR_TXEMPTY_DLY_CYC  2
`define USR_TXEMPTY_DLY  (`USR_TXEMPTY_DLY_CYC * 100 / 100)
`endif

// ### core/usr_pkg.sv
package usr_pkg;
	// one register word
	typedef logic [15:0] usr_word_t;
	// receiver states, gray coded along the frame
	typedef enum logic [2:0] {
		USR_RX_IDLE  = 3'h0,
		USR_RX_START = 3'h1,
		USR_RX_DATA  = 3'h3,
		USR_RX_PAR   = 3'h2,
		USR_RX_STOP  = 3'h6,
		USR_RX_STOP2 = 3'h7
	} usr_rx_state_t;
endpackage

// ### core/usr_rx_mem.sv
`timescale 1ns/1ps
// receive buffer storage with registered, write-first read port
module usr_rx_mem #(
	parameter int W  = 11,
	parameter int AW = 2
) (
	// clock
	input  wire logic          i_clk,
	// write side
	input  wire logic          i_we,
	input  wire logic [AW-1:0] i_waddr,
	input  wire logic [W-1:0]  i_wdata,
	// read side
	input  wire logic [AW-1:0] i_raddr,
	output logic      [W-1:0]  o_rdata
);
	logic [W-1:0] mem [(1<<AW)];   // entries

	// ****************************************************************
	// write port
	// ****************************************************************
	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	// ****************************************************************
	// registered read, bypass avoids stale head after a push
	// ****************************************************************
	always_ff @(posedge i_clk) begin
		if (i_we && (i_waddr == i_raddr)) begin
			o_rdata <= i_wdata;
		end else begin
			o_rdata <= mem[i_raddr];
		end
	end
endmodule

// ### core/usr_rx_top.sv
`timescale 1ns/1ps
`include "usr_regs.svh"
// Notes on behaviour
// - invert bit makes low receive line idle; transmit line always idles high
// - bit spans 4 or 16 baud ticks
// - format field picks data width, parity
// - stop select gives one or two stops
// - rx interrupt at 4, 3 or every character
// - address mode keeps ninth-bit-set characters only, in nine-bit format
// - idle flag high while receiver idle
// - parity flag follows buffer head character
// - framing flag follows buffer head character
// - overrun set when full buffer receives
// - clearing overrun empties buffer and shifter
// - data available while buffer not empty
// - tx empty flag lags write two cycles
module usr_rx_top #(
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_reset,
	// register port
	input  wire logic [2:0]        i_addr,
	input  wire usr_pkg::usr_word_t i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output usr_pkg::usr_word_t     o_rdata,
	// serial line
	input  wire logic              i_serial_rx_line,
	output logic                   o_serial_tx_line,
	// interrupt
	output logic                   o_irq
);
	import usr_pkg::*;
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	// ****************************************************************
	// registers and state
	// ****************************************************************
	usr_word_t     mode;            // mode control
	logic [1:0]    rx_interrupt_select;
	logic          address_detect_enable;
	logic          overrun_flag;
	logic [15:0]   baud_div;        // baud generator divisor
	logic [15:0]   baud_cnt;
	logic [3:0]    irq_stat;        // sticky events
	logic [3:0]    irq_mask;
	usr_rx_state_t rx_state;
	logic [4:0]    os_cnt;          // rx oversample counter
	logic [3:0]    bit_cnt;
	logic [8:0]    rx_shift_register;
	logic          par_bit;
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0]   count;
	logic [10:0]   head;            // {framing_error_flag, parity_error_flag, data}
	logic [8:0]    tx_data_register;
	logic [1:0]    tx_pend;         // write delay line
	logic          tx_full;
	logic          tx_busy;
	logic [12:0]   tx_frame;
	logic [3:0]    tx_left;
	logic [4:0]    tx_os;

	// ****************************************************************
	// decode of mode fields and strobes
	// ****************************************************************
	wire serial_port_enable     = mode[`USR_MODE_EN];
	wire rx_polarity_invert     = mode[`USR_MODE_INV];
	wire high_speed_baud_select = mode[`USR_MODE_HS];
	wire [1:0] frame_format_select =
		mode[`USR_MODE_FMT_HI:`USR_MODE_FMT_LO];
	wire stop_count_select      = mode[`USR_MODE_STOP2];
	wire nine     = frame_format_select == `USR_FMT_NINE;
	wire has_par  = frame_format_select == `USR_FMT_ODD ||
		frame_format_select == `USR_FMT_EVEN;
	wire [4:0] os_len = high_speed_baud_select ? `USR_OS_HS
		: `USR_OS_STD;
	wire tick     = serial_port_enable && (baud_cnt == baud_div);
	wire sample   = tick && (os_cnt == os_len - 5'h01);
	wire line_n   = i_serial_rx_line ^ rx_polarity_invert;
	wire wr_sta   = i_wr && (i_addr == `USR_OFF_STATUS);
	wire wr_tx    = i_wr && (i_addr == `USR_OFF_TXDATA);
	wire flush    = wr_sta && overrun_flag && !i_wdata[`USR_STA_OVR];
	wire frame_done = (rx_state == USR_RX_STOP) && sample;
	wire p_calc   = ^rx_shift_register[8:1] ^ par_bit;
	wire parity_error_flag_new = (frame_format_select == `USR_FMT_ODD) ? !p_calc
		: (frame_format_select == `USR_FMT_EVEN) ? p_calc : 1'b0;
	wire [8:0] data_new = nine ? rx_shift_register
		: {1'b0, rx_shift_register[8:1]};
	wire drop     = address_detect_enable && nine && !data_new[8];
	wire push     = frame_done && !drop;
	wire full     = count == FULL;
	wire push_ok  = push && !full;
	wire rx_data_available = count != '0;
	wire pop      = i_rd && (i_addr == `USR_OFF_RXDATA) && rx_data_available;
	wire [AW-1:0] next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
	wire [AW:0] count_after = count + 1'b1;
	wire tx_shift_empty = !tx_busy && !tx_full;
	wire tx_done  = tx_busy && tick && (tx_os == os_len - 5'h01) &&
		(tx_left == 4'h1);

	// ****************************************************************
	// baud generator
	// ****************************************************************
	always_ff @(posedge i_clk) begin
		if (i_reset || !serial_port_enable || tick) begin
			baud_cnt <= '0;
		end else begin
			baud_cnt <= baud_cnt + 16'h0001;
		end
	end

	// ****************************************************************
	// receive state machine
	// ****************************************************************
	always_ff @(posedge i_clk) begin
		if (i_reset || flush || !serial_port_enable) begin
			rx_state <= USR_RX_IDLE;
			os_cnt <= '0;
			bit_cnt <= '0;
			rx_shift_register <= '0;
			par_bit <= 1'b0;
		end else begin
			case (rx_state)
			USR_RX_IDLE: begin
				// start bit is the non-idle level
				if (!line_n) begin
					rx_state <= USR_RX_START;
					os_cnt <= '0;
				end
			end
			USR_RX_START: begin
				// half a bit, then confirm at its centre
				if (tick) begin
					if (os_cnt == (os_len >> 1) - 5'h01) begin
						os_cnt <= '0;
						bit_cnt <= '0;
						rx_shift_register <= '0;
						rx_state <= line_n ? USR_RX_IDLE : USR_RX_DATA;
					end else begin
						os_cnt <= os_cnt + 5'h01;
					end
				end
			end
			default: begin
				// data, parity and stop bits, one per os_len ticks
				if (sample) begin
					os_cnt <= '0;
				end else if (tick) begin
					os_cnt <= os_cnt + 5'h01;
				end
				if (sample) begin
					case (rx_state)
					USR_RX_DATA: begin
						// lsb first into the shifter
						rx_shift_register <=
							{line_n, rx_shift_register[8:1]};
						bit_cnt <= bit_cnt + 4'h1;
						if (bit_cnt == (nine ? 4'h8 : 4'h7)) begin
							rx_state <= has_par ? USR_RX_PAR : USR_RX_STOP;
						end
					end
					USR_RX_PAR: begin
						par_bit <= line_n;
						rx_state <= USR_RX_STOP;
					end
					USR_RX_STOP: begin
						// second stop keeps receiver busy one more bit
						rx_state <= stop_count_select ? USR_RX_STOP2
							: USR_RX_IDLE;
					end
					default: begin
						rx_state <= USR_RX_IDLE;
					end
					endcase
				end
			end
			endcase
		end
	end

	// ****************************************************************
	// receive buffer pointers and fill level
	// ****************************************************************
	always_ff @(posedge i_clk) begin
		if (i_reset || flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push_ok) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			rd_ptr <= next_rd_ptr;
			if (push_ok && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push_ok) begin
				count <= count - 1'b1;
			end
		end
	end

	usr_rx_mem #(.W(11), .AW(AW)) u_mem (
		.i_clk   (i_clk),
		.i_we    (push_ok),
		.i_waddr (wr_ptr),
		.i_wdata ({!line_n, parity_error_flag_new, data_new}),
		.i_raddr (next_rd_ptr),
		.o_rdata (head)
	);

	// ****************************************************************
	// overrun flag, hardware set wins over software clear
	// ****************************************************************
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			overrun_flag <= 1'b0;
		end else if (push && full) begin
			overrun_flag <= 1'b1;
		end else if (flush) begin
			overrun_flag <= 1'b0;
		end
	end

	// ****************************************************************
	// software written configuration
	// ****************************************************************
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			mode <= `USR_RST_MODE;
			rx_interrupt_select <= 2'h0;
			address_detect_enable <= 1'b0;
			baud_div <= `USR_RST_BAUD_DIV;
			irq_mask <= `USR_RST_MASK;
		end else if (i_wr) begin
			case (i_addr)
			`USR_OFF_MODE: mode <= i_wdata & 16'h801F;
			`USR_OFF_STATUS: begin
				rx_interrupt_select <=
					i_wdata[`USR_STA_RXSEL_HI:`USR_STA_RXSEL_LO];
				address_detect_enable <= i_wdata[`USR_STA_ADDRESS_DETECT_ENABLE];
			end
			`USR_OFF_BAUD_DIV: baud_div <= i_wdata;
			`USR_OFF_IRQ_MASK: irq_mask <= i_wdata[3:0];
			default: begin
			end
			endcase
		end
	end

	// ****************************************************************
	// sticky interrupt status, read clears, new event wins
	// ****************************************************************
	logic [3:0] ev;
	always_comb begin
		ev = 4'h0;
		if (push_ok) begin
			case (rx_interrupt_select)
			`USR_RXSEL_FOUR:  ev[`USR_IRQ_RX] = count_after == FULL;
			`USR_RXSEL_THREE: ev[`USR_IRQ_RX] = count_after == FULL - 1'b1;
			default:          ev[`USR_IRQ_RX] = 1'b1;
			endcase
		end
		ev[`USR_IRQ_OVR] = push && full;
		ev[`USR_IRQ_ERR] = push_ok && (!line_n || parity_error_flag_new);
		ev[`USR_IRQ_TXDONE] = tx_done;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			irq_stat <= 4'h0;
		end else if (i_rd && (i_addr == `USR_OFF_IRQ_STAT)) begin
			irq_stat <= ev;
		end else begin
			irq_stat <= irq_stat | ev;
		end
	end

	assign o_irq = |(irq_stat & irq_mask);

	// ****************************************************************
	// transmitter: two-cycle write delay, then frame shifter
	// ****************************************************************
	logic [12:0] next_tx_frame;
	always_comb begin
		next_tx_frame = 13'h1FFF;
		next_tx_frame[0] = 1'b0;
		if (nine) begin
			next_tx_frame[9:1] = tx_data_register;
		end else begin
			next_tx_frame[8:1] = tx_data_register[7:0];
			if (has_par) begin
				next_tx_frame[9] = ^tx_data_register[7:0] ^
					(frame_format_select == `USR_FMT_ODD);
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			tx_pend <= 2'h0;
			tx_full <= 1'b0;
			tx_data_register <= '0;
		end else begin
			tx_pend <= {tx_pend[0], wr_tx};
			if (wr_tx) begin
				tx_data_register <= i_wdata[8:0];
			end
			if (tx_pend[`USR_TXEMPTY_DLY - 1]) begin
				tx_full <= 1'b1;
			end else if (!tx_busy && serial_port_enable) begin
				tx_full <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset || !serial_port_enable) begin
			tx_busy <= 1'b0;
			tx_frame <= 13'h1FFF;
			tx_left <= 4'h0;
			tx_os <= '0;
		end else if (!tx_busy && tx_full) begin
			tx_busy <= 1'b1;
			tx_frame <= next_tx_frame;
			tx_left <= 4'h1 + (nine || has_par ? 4'h9 : 4'h8) +
				(stop_count_select ? 4'h2 : 4'h1);
			tx_os <= '0;
		end else if (tx_busy && tick) begin
			if (tx_os == os_len - 5'h01) begin
				tx_os <= '0;
				tx_frame <= {1'b1, tx_frame[12:1]};
				tx_left <= tx_left - 4'h1;
				tx_busy <= tx_left != 4'h1;
			end else begin
				tx_os <= tx_os + 5'h01;
			end
		end
	end

	assign o_serial_tx_line = tx_frame[0];

	// ****************************************************************
	// register read, data stand one cycle after the strobe
	// ****************************************************************
	always_ff @(posedge i_clk) begin
		if (i_reset || !i_rd) begin
			o_rdata <= 16'h0000;
		end else begin
			case (i_addr)
			`USR_OFF_MODE:     o_rdata <= mode;
			`USR_OFF_STATUS:   o_rdata <= {7'h00, tx_shift_empty,
				rx_interrupt_select, address_detect_enable,
				rx_state == USR_RX_IDLE,
				rx_data_available && head[9],
				rx_data_available && head[10],
				overrun_flag, rx_data_available};
			`USR_OFF_TXDATA:   o_rdata <= {7'h00, tx_data_register};
			`USR_OFF_RXDATA:   o_rdata <= {7'h00, head[8:0]};
			`USR_OFF_IRQ_STAT: o_rdata <= {12'h000, irq_stat};
			`USR_OFF_IRQ_MASK: o_rdata <= {12'h000, irq_mask};
			`USR_OFF_BAUD_DIV: o_rdata <= baud_div;
			default:           o_rdata <= 16'h0000;
			endcase
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	sequence s_tx_write_idle;
		wr_tx && tx_shift_empty && (tx_pend == 2'h0);
	endsequence
	sequence s_empty_then_busy;
		tx_shift_empty [*3] ##1 !tx_shift_empty;
	endsequence

	// start bit is the pin level equal to the invert bit
	AST_START_LEVEL: assert property (
		(rx_state == USR_RX_IDLE && serial_port_enable && !flush &&
		 (i_serial_rx_line == rx_polarity_invert)) |=>
		rx_state == USR_RX_START)
		else $error("start level not taken");
	// oversample counter never runs past one bit time
	AST_OS_LEN: assert property (
		(rx_state != USR_RX_IDLE) |->
		(os_cnt < (high_speed_baud_select ? 5'h04 : 5'h10)))
		else $error("oversample length wrong");
	// eighth data bit ends the data phase unless nine-bit format
	AST_DATA_BITS: assert property (
		(sample && !flush && rx_state == USR_RX_DATA &&
		 bit_cnt == 4'h7) |=>
		((rx_state == USR_RX_DATA) == $past(nine)))
		else $error("data bit count wrong for format");
	AST_RX_IRQ_FOUR: assert property (
		(push_ok && !pop && rx_interrupt_select == 2'h3 &&
		 count == FULL - 1'b1) |=> irq_stat[`USR_IRQ_RX])
		else $error("rx interrupt missed at full");
	AST_ADDR_DROP: assert property (
		(frame_done && address_detect_enable && nine &&
		 !rx_shift_register[8]) |-> !push)
		else $error("data character stored in address mode");
	AST_OVERRUN: assert property (
		(push && full) |=> overrun_flag &&
		(count == FULL || $past(pop) || $past(flush)))
		else $error("overrun not flagged");
	AST_FLUSH: assert property (
		flush |=> count == '0 && rx_state == USR_RX_IDLE)
		else $error("flush left data behind");
	AST_AVAIL: assert property (
		(rx_data_available && !pop && !flush) |=> rx_data_available)
		else $error("data available dropped without read");
	AST_TXEMPTY_DELAY: assert property (
		s_tx_write_idle |-> s_empty_then_busy)
		else $error("tx empty flag timing wrong");
	AST_FRAMING_ERROR_FLAG_STORE: assert property (
		(push_ok && !line_n) |=> ##1
		u_mem.mem[$past(wr_ptr, 2)][10])
		else $error("framing error not stored");
endmodule

// ### bench/usr_line_model.sv
`timescale 1ns/1ps
// ****************************************************************
// remote serial transmitter on the receive line
// ****************************************************************
module usr_line_model (
	// clock and line polarity
	input  wire logic i_clk,
	input  wire logic i_inv,
	// serial line toward the device
	output logic      o_line
);
	logic lvl; // logical level, 1 means idle
	initial begin
		lvl = 1'b1;
	end
	// polarity applied at the pin only
	assign o_line = lvl ^ i_inv;
	// one frame; bp flips parity, bs makes the first stop non-idle
	task automatic send(input logic [8:0] d, input logic [1:0] fmt,
		input logic two, input int bclk, input logic bp, input logic bs);
		logic p; // parity bit to send
		p = ^d[7:0] ^ fmt[1] ^ bp;
		@(posedge i_clk);
		lvl <= 1'b0;
		repeat (bclk) @(posedge i_clk);
		// data bits, least significant first
		for (int i = 0; i < ((fmt == 2'h3) ? 9 : 8); i++) begin
			lvl <= d[i];
			repeat (bclk) @(posedge i_clk);
		end
		// parity only in the two parity formats
		if (fmt == 2'h1 || fmt == 2'h2) begin
			lvl <= p;
			repeat (bclk) @(posedge i_clk);
		end
		// bad stop covers the centre, then returns to idle
		if (bs) begin
			lvl <= 1'b0;
			repeat (bclk * 3 / 4) @(posedge i_clk);
			lvl <= 1'b1;
			repeat (bclk / 4) @(posedge i_clk);
		end else begin
			lvl <= 1'b1;
			repeat (bclk) @(posedge i_clk);
		end
		// second stop bit at idle level
		if (two) begin
			repeat (bclk) @(posedge i_clk);
		end
	endtask
endmodule

// ### bench/usr_rx_top_tb_top.sv
`timescale 1ns/1ps
`include "usr_regs.svh"
module usr_rx_top_tb_top;
	import usr_pkg::*;
	// ****************************************************************
	// signals
	// ****************************************************************
	localparam int DEPTH = 4; // receive buffer depth
	logic       i_clk;      // bench clock
	logic       i_reset;    // synchronous reset
	logic [2:0] i_addr;     // register index
	usr_word_t  i_wdata;    // write data
	logic       i_wr;       // write strobe
	logic       i_rd;       // read strobe
	usr_word_t  o_rdata;    // read data
	logic       rx_line;    // line from the model
	logic       line_inv;   // polarity seen by the model
	logic       o_serial_tx_line; // transmit line
	logic       o_irq;      // interrupt
	int         fail_count; // mismatches
	int         cmp_count;  // comparisons
	logic [1:0] cur_fmt;    // current format
	logic       cur_two;    // current stop count
	int         cur_bclk;   // clocks per bit
	logic [8:0] d;          // random character
	usr_word_t  w;          // scratch read value
	int         thr;        // interrupt threshold
	// ****************************************************************
	// design, partner and clock
	// ****************************************************************
	usr_rx_top #(.DEPTH(DEPTH)) dut (.i_clk(i_clk), .i_reset(i_reset),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_serial_rx_line(rx_line),
		.o_serial_tx_line(o_serial_tx_line), .o_irq(o_irq));
	usr_line_model line (.i_clk(i_clk), .i_inv(line_inv), .o_line(rx_line));
	// 100 ns period
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	// ****************************************************************
	// bus tasks, compares and expectations
	// ****************************************************************
	task automatic reg_wr(input logic [2:0] a, input usr_word_t v);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	// data sampled in the single cycle after the taken edge
	task automatic reg_rd(input logic [2:0] a, output usr_word_t v);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask
	task automatic cmp_word(input usr_word_t got, input usr_word_t exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// read, mask and compare
	task automatic chk_rd(input logic [2:0] a, input usr_word_t m,
		input usr_word_t exp);
		usr_word_t v; // value read
		reg_rd(a, v);
		cmp_word(v & m, exp);
	endtask
	function automatic usr_word_t mode_word(input logic inv, input logic hs,
		input logic [1:0] fmt, input logic two);
		return {1'b1, 10'h000, inv, hs, fmt, two};
	endfunction
	function automatic usr_word_t exp_data(input logic [8:0] v,
		input logic [1:0] fmt);
		return (fmt == 2'h3) ? {7'h00, v} : {8'h00, v[7:0]};
	endfunction
	// disable first so a polarity change cannot start a frame
	task automatic set_mode(input logic inv, input logic hs,
		input logic [1:0] fmt, input logic two);
		reg_wr(`USR_OFF_MODE, 16'h0000);
		line_inv <= inv;
		cur_fmt = fmt;
		cur_two = two;
		cur_bclk = (hs ? 4 : 16) * 2;
		reg_wr(`USR_OFF_MODE, mode_word(inv, hs, fmt, two));
		repeat (8) @(posedge i_clk);
	endtask
	task automatic frame(input logic [8:0] v, input logic bp, input logic bs);
		line.send(v, cur_fmt, cur_two, cur_bclk, bp, bs);
		repeat (8) @(posedge i_clk);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (100000) @(posedge i_clk);
		fail_count++;
		report_and_stop();
	end
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		i_reset = 1'b1;
		i_addr = 3'h0;
		i_wdata = 16'h0000;
		i_wr = 1'b0;
		i_rd = 1'b0;
		line_inv = 1'b0;
		fail_count = 0;
		cmp_count = 0;
		void'($urandom(32'h20BB));
		repeat (20) @(posedge i_clk);
		i_reset <= 1'b0;
		// reset values and an unmapped index
		chk_rd(`USR_OFF_MODE, 16'hFFFF, `USR_RST_MODE);
		chk_rd(`USR_OFF_BAUD_DIV, 16'hFFFF, `USR_RST_BAUD_DIV);
		chk_rd(`USR_OFF_IRQ_MASK, 16'h000F, {12'h000, `USR_RST_MASK});
		chk_rd(3'h7, 16'hFFFF, 16'h0000);
		reg_wr(`USR_OFF_BAUD_DIV, 16'h0001);
		// every format, stop count, speed, random polarity and data
		for (int k = 0; k < 16; k++) begin
			set_mode(1'($urandom % 2), k[3], k[1:0], k[2]);
			d = 9'($urandom);
			fork
				frame(d, 1'b0, 1'b0);
				begin
					repeat (cur_bclk * 4) @(posedge i_clk);
					chk_rd(`USR_OFF_STATUS, 16'h0010, 16'h0000);
				end
			join
			chk_rd(`USR_OFF_STATUS, 16'h001F, 16'h0011);
			chk_rd(`USR_OFF_RXDATA, 16'hFFFF, exp_data(d, cur_fmt));
			chk_rd(`USR_OFF_STATUS, 16'h0001, 16'h0000);
		end
		// parity error then framing error follow the head character
		set_mode(1'b0, 1'b0, `USR_FMT_EVEN, 1'b0);
		frame(9'h0A7, 1'b1, 1'b0);
		chk_rd(`USR_OFF_STATUS, 16'h000D, 16'h0009);
		reg_rd(`USR_OFF_RXDATA, w);
		frame(9'h03C, 1'b0, 1'b1);
		chk_rd(`USR_OFF_STATUS, 16'h000D, 16'h0005);
		reg_rd(`USR_OFF_RXDATA, w);
		chk_rd(`USR_OFF_STATUS, 16'h000D, 16'h0000);
		// overrun on a full buffer, then software clear flushes
		set_mode(1'b0, 1'b1, 2'h0, 1'b0);
		reg_wr(`USR_OFF_IRQ_MASK, 16'h0002);
		repeat (DEPTH + 1) frame(9'($urandom), 1'b0, 1'b0);
		chk_rd(`USR_OFF_STATUS, 16'h0003, 16'h0003);
		cmp_bit(o_irq, 1'b1);
		reg_wr(`USR_OFF_STATUS, 16'h0000);
		chk_rd(`USR_OFF_STATUS, 16'h0003, 16'h0000);
		frame(9'h05A, 1'b0, 1'b0);
		chk_rd(`USR_OFF_RXDATA, 16'hFFFF, 16'h005A);
		chk_rd(`USR_OFF_IRQ_STAT, 16'h0002, 16'h0002);
		cmp_bit(o_irq, 1'b0);
		// receive interrupt thresholds for every selection code
		reg_wr(`USR_OFF_IRQ_MASK, 16'h0001);
		for (int s = 3; s >= 0; s--) begin
			thr = (s == 3) ? 4 : (s == 2) ? 3 : 1;
			reg_rd(`USR_OFF_IRQ_STAT, w);
			reg_wr(`USR_OFF_STATUS, 16'(s) << 6);
			for (int n = 1; n <= thr; n++) begin
				frame(9'($urandom), 1'b0, 1'b0);
				cmp_bit(o_irq, n == thr);
			end
			repeat (thr) reg_rd(`USR_OFF_RXDATA, w);
		end
		// address detect in nine-bit format, no effect in eight-bit
		set_mode(1'b0, 1'b1, `USR_FMT_NINE, 1'b0);
		reg_wr(`USR_OFF_STATUS, 16'h0020);
		frame(9'h055, 1'b0, 1'b0);
		chk_rd(`USR_OFF_STATUS, 16'h0001, 16'h0000);
		frame(9'h1A5, 1'b0, 1'b0);
		chk_rd(`USR_OFF_RXDATA, 16'hFFFF, 16'h01A5);
		set_mode(1'b0, 1'b1, 2'h0, 1'b0);
		frame(9'h055, 1'b0, 1'b0);
		chk_rd(`USR_OFF_RXDATA, 16'hFFFF, 16'h0055);
		// transmit empty flag lags the data write
		chk_rd(`USR_OFF_STATUS, 16'h0100, 16'h0100);
		reg_wr(`USR_OFF_TXDATA, 16'h00A5);
		chk_rd(`USR_OFF_STATUS, 16'h0100, 16'h0100);
		repeat (5) @(posedge i_clk);
		cmp_bit(o_serial_tx_line, 1'b0);
		// mid-bit samples: data 0xA5 lsb first, then stop at 1
		for (int i = 0; i < 9; i++) begin
			repeat (8) @(posedge i_clk);
			cmp_bit(o_serial_tx_line, 1'(9'h1A5 >> i));
		end
		chk_rd(`USR_OFF_STATUS, 16'h0100, 16'h0000);
		repeat (12 * 8) @(posedge i_clk);
		chk_rd(`USR_OFF_STATUS, 16'h0100, 16'h0100);
		report_and_stop();
	end
endmodule
